// file: inc/clk_switch_pkg.sv
// Purpose: Shared constants and types of the system clock source switch.
// Assumes: Core clock of 100 MHz; register data is eight bits wide.
// Notes:   Delay times are kept in nanoseconds and turned into cycles here.
package clk_switch_pkg;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int OST_CYCLES       = 1024;
  localparam int INT_START_NS     = 2000;
  localparam int INT_START_CYCLES =
    (INT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_NS          = 3000;
  localparam int WARM_CYCLES      =
    (WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_NS      = 2000000;
  localparam int PLL_LOCK_CYCLES  =
    (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets.
  localparam logic [1:0] OSC_CTRL_ADDR   = 2'h0;
  localparam logic [1:0] OSC_STAT_ADDR   = 2'h1;
  localparam logic [1:0] TIMER_CTRL_ADDR = 2'h2;

  // Field positions.
  localparam int SPLL_BIT     = 7;
  localparam int INTERNAL_FREQ_SELECT_LSB     = 3;
  localparam int SCS_LSB      = 0;
  localparam int TOSC_EN_BIT  = 3;

  // Values after reset and field encodings.
  localparam logic [3:0] INTERNAL_FREQ_SELECT_RESET    = 4'h7;
  localparam logic [1:0] SCS_RESET     = 2'h0;
  localparam logic [3:0] INTERNAL_FREQ_SELECT_8MHZ     = 4'hE;
  localparam logic [1:0] SCS_CONFIG    = 2'h0;
  localparam logic [1:0] SCS_TIMER     = 2'h1;
  localparam logic [2:0] OSC_CFG_LP    = 3'h0;
  localparam logic [2:0] OSC_CFG_XT    = 3'h1;
  localparam logic [2:0] OSC_CFG_HS    = 3'h2;
  localparam logic [2:0] OSC_CFG_INT   = 3'h4;
  localparam logic [2:0] OSC_CFG_RESET = 3'h4;

  typedef enum logic [2:0] {
    src_none, src_ext, src_timer, src_hf, src_mf, src_lf
  } src_e;

  typedef enum logic [2:0] {
    sw_idle, sw_wait_ready, sw_wait_fall, sw_hold_low, sw_update
  } sw_state_e;
endpackage

// file: logic/system_clock_source_switch.sv
// Purpose: Selects the system clock source and switches it without glitches.
// Assumes: Oscillators arrive as free levels from other domains; config
//          straps, power-up and sleep events come from logic on clk.
// Notes:   The switched clock is a sampled copy, good for sequencing only.

// Notes on behaviour
// - Config PLL bit forces the PLL on; plain 8 MHz vanishes.
// - A powered-down internal oscillator runs a start-up delay before use.
// - Wait for falling edge of old clock, hold low, take new at rise.
// - Oscillator status updates after the new clock is active.
// - Frequency change within the same source takes effect with no delay.
// - Select 00 config source, 01 timer oscillator, 1x internal block.
// - Every reset clears the clock source select field.
// - Automatic switches leave the clock source select field untouched.
// - Timeout status is one on the configured external source, else zero.
// - Startup timer result ignores timer oscillator readiness.
// - Timer oscillator runs only while its enable bit is set.
// - Crystal modes count 1024 oscillator cycles before use.
// - Two-speed start-up is off outside the three crystal modes.
// - Two-speed runs internal, then after 1024 cycles moves to external.
// - Sleep aborts start-up counting and leaves timeout status clear.
// - Two-speed needs enable strap, select 00 and crystal config.
// - Two-speed begins after power-up timer expiry or wake from sleep.
// - Internal oscillator after sleep or reset waits a warm-up delay unless the PLL is on.
// - Crystal after sleep needs 1024 counted cycles; the timer oscillator count survives sleep.
// - Soft PLL bit only matters while the config PLL bit is zero.
module system_clock_source_switch
  import clk_switch_pkg::*;
#(
  parameter int PLL_LOCK = clk_switch_pkg::PLL_LOCK_CYCLES,
  parameter int INT_START = clk_switch_pkg::INT_START_CYCLES,
  parameter int WARM = clk_switch_pkg::WARM_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // Register port
  input  wire logic [1:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  // Configuration straps
  input  wire logic [2:0]                  system_oscillator_config,
  input  wire logic                        config_pll_enable,
  input  wire logic                        two_speed_enable,
  // Power events
  input  wire logic                        powerup_done,
  input  wire logic                        sleep_enter,
  input  wire logic                        wake_event,
  // Oscillator levels
  input  wire logic                        ext_osc_in,
  input  wire logic                        timer_osc_in,
  input  wire logic                        hf_osc_in,
  input  wire logic                        mf_osc_in,
  input  wire logic                        lf_osc_in,
  // Clock and oscillator control
  output logic                             sys_clk_out,
  output clk_switch_pkg::src_e             active_source,
  output logic      [3:0]                  active_freq_select,
  output logic                             pll_engaged,
  output logic                             timer_osc_run,
  output logic      [2:0]                  int_osc_enable,
  output logic                             switch_busy
);
  import clk_switch_pkg::*;

  function automatic src_e freq_source(input logic [3:0] f);
    if (f[3]) return src_hf;
    else if (f[3:1] == 3'h0) return src_lf;
    else if (f == 4'h3) return src_hf;
    else return src_mf;
  endfunction

  function automatic logic is_crystal(input logic [2:0] c);
    return (c == OSC_CFG_LP) || (c == OSC_CFG_XT) || (c == OSC_CFG_HS);
  endfunction

  // Software state.
  logic       soft_pll_enable;
  logic [3:0] internal_freq_select;
  logic [1:0] clock_source_select;
  logic       timer_osc_enable;
  // Captured straps.
  logic       strap_taken;
  logic [2:0] osc_cfg;
  logic       pll_cfg;
  logic       tss_cfg_bit;
  // Power state.
  logic       powered_up;
  logic       asleep;
  logic       awake_d;
  logic       warm_mode;
  // Oscillator sampling.
  logic [4:0] osc_raw;
  logic [4:0] osc_s1;
  logic [4:0] osc_s2;
  logic [4:0] osc_s3;
  // Counters.
  logic [10:0] ost_cnt;
  logic [10:0] tost_cnt;
  logic [17:0] pll_cnt;
  logic [17:0] int_cnt [3];
  // Switch state.
  sw_state_e  state;
  sw_state_e  next_state;
  src_e       active_src;
  src_e       next_active;
  src_e       pending;
  src_e       next_pending;
  src_e       target;
  logic       startup_timeout_status;
  logic [2:0] stat_osc;

  assign osc_raw = {lf_osc_in, mf_osc_in, hf_osc_in, timer_osc_in, ext_osc_in};

  // Each oscillator is sampled twice before any edge logic sees it.
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          osc_s1[g] <= 1'b0;
          osc_s2[g] <= 1'b0;
          osc_s3[g] <= 1'b0;
        end else begin
          osc_s1[g] <= osc_raw[g];
          osc_s2[g] <= osc_s1[g];
          osc_s3[g] <= osc_s2[g];
        end
      end
    end
  endgenerate

  // Index 0 stands for no source: level low, edges immediate.
  wire [5:0] lvl  = {osc_s2, 1'b0};
  wire [5:0] rise = {osc_s2 & ~osc_s3, 1'b1};
  wire [5:0] fall = {~osc_s2 & osc_s3, 1'b1};

  wire awake      = powered_up && !asleep;
  wire crystal    = is_crystal(osc_cfg);
  wire scs_config = (clock_source_select == SCS_CONFIG);
  // Startup timer counts only external edges; timer readiness is apart.
  wire ost_done   = (ost_cnt == 11'(OST_CYCLES));
  wire tost_done  = (tost_cnt == 11'(OST_CYCLES));
  wire pll_on     = pll_cfg || soft_pll_enable;
  wire pll_ready  = pll_on && (pll_cnt == 18'(PLL_LOCK));
  wire pll_wanted = pll_on && (internal_freq_select == INTERNAL_FREQ_SELECT_8MHZ);
  wire two_speed  = tss_cfg_bit && scs_config && crystal;
  wire ext_ready  = !crystal || ost_done;
  wire timer_ready_flag = !timer_osc_enable || tost_done;
  wire [2:0] int_rdy;
  // Warm-up is owed only after reset or sleep, and not while the PLL runs.
  wire [17:0] int_limit = (warm_mode && !pll_on) ? 18'(WARM)
                                                 : 18'(INT_START);
  src_e int_src;
  assign int_src = freq_source(internal_freq_select);

  // Target source from the select field; two-speed runs internal meanwhile.
  always_comb begin
    target = src_none;
    if (awake) begin
      if (clock_source_select[1]) target = int_src;
      else if (clock_source_select == SCS_TIMER) target = src_timer;
      else if (osc_cfg == OSC_CFG_INT) target = int_src;
      else if (two_speed && !ost_done) target = int_src;
      else target = src_ext;
    end
  end

  wire [5:0] src_ready = {int_rdy[2], int_rdy[1],
                          int_rdy[0] && (!pll_wanted || pll_ready),
                          timer_osc_enable && tost_done, ext_ready, 1'b1};

  // Internal oscillators: powered while used, delayed after power-up.
  generate
    for (g = 0; g < 3; g++) begin : g_int
      wire src_e me = src_e'(3'(g + 3));
      wire powered = awake && ((active_src == me) || (target == me) ||
                               (pending == me));
      assign int_osc_enable[2 - g] = powered;
      assign int_rdy[g] = powered && (int_cnt[g] >= int_limit);
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) int_cnt[g] <= 18'h0;
        else if (!powered) int_cnt[g] <= 18'h0;
        else if (int_cnt[g] < int_limit)
          int_cnt[g] <= int_cnt[g] + 18'h1;
      end
    end
  endgenerate

  // Switch sequencer.
  always_comb begin
    next_state   = state;
    next_active  = active_src;
    next_pending = pending;
    case (state)
      sw_idle: begin
        if (target != active_src) begin
          next_pending = target;
          next_state   = sw_wait_ready;
        end
      end
      sw_wait_ready: begin
        next_pending = target;
        if (target == active_src) next_state = sw_idle;
        else if (src_ready[target]) next_state = sw_wait_fall;
      end
      sw_wait_fall: begin
        if (fall[active_src]) next_state = sw_hold_low;
      end
      sw_hold_low: begin
        if (rise[pending]) begin
          next_active = pending;
          next_state  = sw_update;
        end
      end
      sw_update: next_state = sw_idle;
      default:   next_state = sw_idle;
    endcase
    // Sleep wins over a switch in flight; the next wake starts from no source.
    if (sleep_enter) begin
      next_state  = sw_idle;
      next_active = src_none;
    end
  end

  // Taken from the next state so the clock drops with the sequencer.
  wire hold_low = (next_state == sw_hold_low);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= sw_idle;
      active_src <= src_none;
      pending    <= src_none;
    end else begin
      state      <= next_state;
      active_src <= next_active;
      pending    <= next_pending;
    end
  end

  // Outside sleep the output shows no short pulse: low is held across the change; sleep drops it at once.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sys_clk_out <= 1'b0;
    else sys_clk_out <= hold_low ? 1'b0 : lvl[next_active];
  end

  // Status follows the completed switch only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_timeout_status     <= 1'b0;
      stat_osc <= 3'h0;
    end else if (sleep_enter) begin
      startup_timeout_status     <= 1'b0;
      stat_osc <= 3'h0;
    end else if (state == sw_update) begin
      startup_timeout_status     <= (active_src == src_ext);
      stat_osc <= {int_rdy[0], int_rdy[1], int_rdy[2]};
    end
  end

  // Applied frequency moves at once when the source stays the same.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) active_freq_select <= INTERNAL_FREQ_SELECT_RESET;
    else if ((state == sw_update) ||
             ((state == sw_idle) && (target == active_src)))
      active_freq_select <= internal_freq_select;
  end

  // Startup timers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ost_cnt <= 11'h0;
    else if (sleep_enter || !awake || !scs_config || !crystal)
      ost_cnt <= 11'h0;
    else if (!ost_done && rise[1]) ost_cnt <= ost_cnt + 11'h1;
  end

  // Timer readiness keeps its own count; the crystal timer never waits on it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tost_cnt <= 11'h0;
    else if (!timer_osc_enable) tost_cnt <= 11'h0;
    else if (!tost_done && rise[2]) tost_cnt <= tost_cnt + 11'h1;
  end

  // Lock time restarts when the PLL goes off, so a quick toggle pays it again.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pll_cnt <= 18'h0;
    else if (!pll_on) pll_cnt <= 18'h0;
    else if (pll_cnt != 18'(PLL_LOCK)) pll_cnt <= pll_cnt + 18'h1;
  end

  // Straps are caught on the first edge after reset release.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken <= 1'b0;
      osc_cfg     <= OSC_CFG_RESET;
      pll_cfg     <= 1'b0;
      tss_cfg_bit <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      osc_cfg     <= system_oscillator_config;
      pll_cfg     <= config_pll_enable;
      tss_cfg_bit <= two_speed_enable;
    end
  end

  // Power state; wake or power-up restarts with warm-up timing.
  // Sleep beats a wake in the same cycle, so a late wake cannot cancel it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      powered_up <= 1'b0;
      asleep     <= 1'b0;
      awake_d    <= 1'b0;
      warm_mode  <= 1'b1;
    end else begin
      if (powerup_done) powered_up <= 1'b1;
      if (sleep_enter) asleep <= 1'b1;
      else if (wake_event) asleep <= 1'b0;
      awake_d <= awake;
      if (awake && !awake_d) warm_mode <= 1'b1;
      else if (state == sw_update) warm_mode <= 1'b0;
    end
  end

  // Register port.
  wire sel_ctrl  = (reg_addr == OSC_CTRL_ADDR);
  wire sel_stat  = (reg_addr == OSC_STAT_ADDR);
  wire sel_timer = (reg_addr == TIMER_CTRL_ADDR);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_pll_enable      <= 1'b0;
      internal_freq_select <= INTERNAL_FREQ_SELECT_RESET;
      clock_source_select  <= SCS_RESET;
      timer_osc_enable     <= 1'b0;
    end else if (reg_wr && sel_ctrl) begin
      soft_pll_enable      <= reg_wdata[SPLL_BIT];
      internal_freq_select <= reg_wdata[INTERNAL_FREQ_SELECT_LSB +: 4];
      clock_source_select  <= reg_wdata[SCS_LSB +: 2];
    end else if (reg_wr && sel_timer) begin
      timer_osc_enable     <= reg_wdata[TOSC_EN_BIT];
    end
  end

  // The status index takes no writes: every status bit is owned by hardware.
  wire [7:0] ctrl_word  = {soft_pll_enable, internal_freq_select, 1'b0,
                           clock_source_select};
  wire [7:0] stat_word  = {timer_ready_flag, pll_ready, startup_timeout_status, stat_osc[2],
                           stat_osc[2], stat_osc[1], stat_osc[0],
                           stat_osc[2]};
  wire [7:0] timer_word = 8'(timer_osc_enable) << TOSC_EN_BIT;
  wire [7:0] read_mux   = sel_ctrl  ? ctrl_word  :
                          sel_stat  ? stat_word  :
                          sel_timer ? timer_word : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) reg_rdata <= 8'h00;
    else reg_rdata <= reg_rd ? read_mux : 8'h00;
  end

  // Outputs.
  assign active_source = active_src;
  // Engaged only once the applied select has caught up with software.
  assign pll_engaged   = pll_wanted && pll_ready &&
                         (active_src == src_hf) &&
                         (active_freq_select == INTERNAL_FREQ_SELECT_8MHZ);
  assign timer_osc_run = timer_osc_enable;
  assign switch_busy   = (state != sw_idle);
endmodule

// file: bench/system_clock_source_switch_properties.sv
// Purpose: Concurrent checks on the clock source switch ports.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Changes into no source come from sleep and skip the hold check.
module system_clock_source_switch_properties
  import clk_switch_pkg::*;
#(
  parameter int PLL_LOCK  = 20,
  parameter int INT_START = 4,
  parameter int WARM      = 4
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 arst_n,
  // Register port
  input wire logic [1:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  // Power event and switch outputs
  input wire logic                 sleep_enter,
  input wire logic                 sys_clk_out,
  input clk_switch_pkg::src_e      active_source,
  input wire logic [3:0]           active_freq_select,
  input wire logic                 pll_engaged,
  input wire logic                 timer_osc_run,
  input wire logic [2:0]           int_osc_enable,
  input wire logic                 switch_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  hold_low_a: assert property (
    $changed(active_source) && active_source != src_none &&
    $past(active_source) != src_none |-> !$past(sys_clk_out))
    else $error("system clock not held low before a source change");
  switch_done_a: assert property (
    $changed(active_source) && active_source != src_none
    |-> ##[1:2] !switch_busy)
    else $error("switch not complete after status update");
  timer_src_a: assert property (
    $changed(active_source) && active_source == src_timer |-> timer_osc_run)
    else $error("timer oscillator active while not running");
  timer_run_a: assert property (
    reg_wr && reg_addr == TIMER_CTRL_ADDR
    |=> timer_osc_run == $past(reg_wdata[TOSC_EN_BIT]))
    else $error("timer oscillator run does not follow its enable");
  sleep_stop_a: assert property (
    sleep_enter |=> active_source == src_none && !sys_clk_out)
    else $error("sleep did not stop the system clock");
  startup_timeout_status_src_a: assert property (
    reg_rd && reg_addr == OSC_STAT_ADDR && !switch_busy
    |=> reg_rdata[5] == ($past(active_source) == src_ext))
    else $error("timeout status disagrees with the active source");
  pll_mode_a: assert property (
    pll_engaged |-> active_source == src_hf &&
    active_freq_select == INTERNAL_FREQ_SELECT_8MHZ)
    else $error("PLL engaged outside the 8 MHz high source");
  osc_power_a: assert property (
    active_source == src_mf |-> int_osc_enable[1])
    else $error("mid oscillator active while powered down");

  cover property (active_source == src_ext);
  cover property (active_source == src_timer);
  cover property (pll_engaged);
  cover property (active_source == src_lf);
endmodule

bind system_clock_source_switch system_clock_source_switch_properties #(
  .PLL_LOCK(PLL_LOCK), .INT_START(INT_START), .WARM(WARM)
) props_i (
  .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sleep_enter, .sys_clk_out, .active_source, .active_freq_select,
  .pll_engaged, .timer_osc_run, .int_osc_enable, .switch_busy
);

// file: bench/system_clock_source_switch_tb.sv
// Purpose: Self-checking bench for the system clock source switch.
// Assumes: Small start-up and lock counts; oscillators derived from clk.
// Notes:   Reads queue their expected byte; a monitor checks each answer.
module system_clock_source_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_switch_pkg::*;
  // Any external mode that is not a crystal; the code itself is arbitrary.
  localparam logic [2:0] CLK_IN_CFG = 3'h3;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       rd_d = 1'b0;
  logic       powerup_done = 1'b0;
  logic       sleep_enter = 1'b0;
  logic       wake_event = 1'b0;
  logic       ext_osc_in = 1'b0;
  logic [2:0] osc_strap = OSC_CFG_XT;
  logic       pll_strap = 1'b0;
  logic [3:0] osc_cnt = 4'h0;
  logic [7:0] reg_rdata;
  logic       sys_clk_out, pll_engaged, timer_osc_run, switch_busy;
  logic [3:0] active_freq_select;
  logic [2:0] int_osc_enable;
  src_e       active_source;
  logic [7:0] exp_q[$], msk_q[$];
  int         bad_count = 0, check_count = 0, cyc = 0;
  int         seed = 32'h22821a79;
  wire  [7:0] flags = {pll_engaged, timer_osc_run, 2'h0, active_freq_select};

  system_clock_source_switch #(.PLL_LOCK(20), .INT_START(4), .WARM(4))
  system_clock_source_switch_i (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .system_oscillator_config(osc_strap), .config_pll_enable(pll_strap),
    .two_speed_enable(1'b1), .powerup_done, .sleep_enter, .wake_event,
    .ext_osc_in, .timer_osc_in(osc_cnt[2]), .hf_osc_in(osc_cnt[1]),
    .mf_osc_in(osc_cnt[2]), .lf_osc_in(osc_cnt[3]), .sys_clk_out,
    .active_source, .active_freq_select, .pll_engaged, .timer_osc_run,
    .int_osc_enable, .switch_busy
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
  endtask

  // Pulses sleep when s is high, wake otherwise.
  task automatic power(input logic s);
    sleep_enter <= s;
    wake_event  <= !s;
    @(posedge clk);
    sleep_enter <= 1'b0;
    wake_event  <= 1'b0;
    @(posedge clk);
  endtask

  // Sampled at the falling edge so that the edge's updates have landed.
  task automatic chk_src(input src_e e, input int lim,
                         input logic [7:0] fe, input logic [7:0] fm);
    int n;
    n = 0;
    @(negedge clk);
    while ((active_source !== e || switch_busy !== 1'b0 ||
            (flags & fm) !== fe) && n < lim) begin
      @(negedge clk);
      n++;
    end
    cmp8(8'(active_source), 8'(e));
    cmp8(flags & fm, fe);
    cmp8({7'h00, switch_busy}, 8'h00);
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (rd_d) begin
      cmp8(reg_rdata & msk_q[0], exp_q[0]);
      void'(msk_q.pop_front());
      void'(exp_q.pop_front());
    end
    rd_d       <= reg_rd;
    osc_cnt    <= osc_cnt + 4'h1;
    ext_osc_in <= 1'($random(seed));
    cyc        <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(OSC_CTRL_ADDR, 8'h38, 8'hFF);
    rd(2'h3, 8'h00, 8'hFF);
    rd(OSC_STAT_ADDR, 8'h80, 8'hA0);
    chk_src(src_none, 4, 8'h00, 8'h00);
    powerup_done <= 1'b1;
    chk_src(src_mf, 2000, 8'h07, 8'h0F);
    rd(OSC_STAT_ADDR, 8'h04, 8'h24);
    chk_src(src_ext, 12000, 8'h00, 8'h00);
    rd(OSC_STAT_ADDR, 8'h20, 8'h20);
    rd(OSC_CTRL_ADDR, 8'h38, 8'hFF);
    power(1'b1);
    chk_src(src_none, 4, 8'h00, 8'h00);
    rd(OSC_STAT_ADDR, 8'h00, 8'h20);
    power(1'b0);
    chk_src(src_mf, 2000, 8'h00, 8'h00);
    power(1'b1);
    power(1'b0);
    chk_src(src_mf, 2000, 8'h00, 8'h00);
    repeat (500) @(posedge clk);
    chk_src(src_mf, 0, 8'h00, 8'h00);
    chk_src(src_ext, 12000, 8'h00, 8'h00);
    wr(OSC_CTRL_ADDR, 8'h7A);
    chk_src(src_hf, 2000, 8'h0F, 8'h0F);
    rd(OSC_STAT_ADDR, 8'h10, 8'h30);
    wr(OSC_CTRL_ADDR, 8'h72);
    chk_src(src_hf, 4, 8'h0E, 8'h0F);
    wr(OSC_CTRL_ADDR, 8'hF2);
    chk_src(src_hf, 400, 8'h8E, 8'h8F);
    wr(OSC_CTRL_ADDR, 8'h72);
    chk_src(src_hf, 400, 8'h0E, 8'h8F);
    wr(OSC_CTRL_ADDR, 8'h02);
    chk_src(src_lf, 2000, 8'h00, 8'h0F);
    rd(OSC_STAT_ADDR, 8'h02, 8'h1F);
    rd(TIMER_CTRL_ADDR, 8'h00, 8'hFF);
    wr(TIMER_CTRL_ADDR, 8'hFF);
    rd(TIMER_CTRL_ADDR, 8'h08, 8'hFF);
    repeat (9000) @(posedge clk);
    rd(OSC_STAT_ADDR, 8'h80, 8'h80);
    wr(OSC_CTRL_ADDR, 8'h39);
    chk_src(src_timer, 200, 8'h40, 8'h40);
    wr(OSC_STAT_ADDR, 8'hFF);
    wr(2'h3, 8'hFF);
    rd(OSC_CTRL_ADDR, 8'h39, 8'hFF);
    rd(OSC_STAT_ADDR, 8'h00, 8'h20);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(OSC_CTRL_ADDR, 8'h38, 8'hFF);
    chk_src(src_mf, 2000, 8'h00, 8'h00);
    osc_strap <= CLK_IN_CFG;
    pll_strap <= 1'b1;
    arst_n    <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk_src(src_ext, 40, 8'h00, 8'h00);
    rd(OSC_STAT_ADDR, 8'h20, 8'h20);
    wr(OSC_CTRL_ADDR, 8'h72);
    chk_src(src_hf, 400, 8'h8E, 8'h8F);
    results();
  end
endmodule
